// ---- core/ccser_cfg.svh ----
// Contract
// - bytes of a frame leave in ascending byte number order.
// - last byte of one frame leaves before first byte of next frame.
// - bits of each byte leave serially, bit position zero first.
// - value MSb sits in lowest numbered bit, so MSb leaves first.
// - reserved bits are driven to zero on transmission.
// - control characters are 8 bits, top bit zero, reference seven-bit code.
// - space appears only as separator between data fields.
// - graphic characters 2/1 to 7/14; semicolon only ends a message.
// - decimal fields hold digits 3/0 to 3/9 without leading zeros.
// - hexadecimal fields hold 3/0 to 3/9 and 4/1 to 4/6, zeros kept.
// - transport adaptation layer adds carriage return and line feed only.
`ifndef CCSER_CFG_SVH
`define CCSER_CFG_SVH

`define CCSER_BYTE_W 8
`define CCSER_FIFO_DEPTH 8
`define CCSER_BIT_LAST 3'h7
`define CCSER_TOP_BIT 7

`define CCSER_CH_SPACE 8'h20
`define CCSER_CH_G0_LO 8'h21
`define CCSER_CH_G0_HI 8'h7E
`define CCSER_CH_SEMI 8'h3B
`define CCSER_CH_DIG0 8'h30
`define CCSER_CH_DIG9 8'h39
`define CCSER_CH_HEX_A 8'h41
`define CCSER_CH_HEX_F 8'h46
`define CCSER_CH_CR 8'h0D
`define CCSER_CH_LF 8'h0A

`endif

// ---- core/ccser_pkg.sv ----
package ccser_pkg;

    // what the source says a byte is; raw frame bytes are not checked
    typedef enum logic [2:0] {
        CCSER_RAW = 3'h0,
        CCSER_TEXT = 3'h1,
        CCSER_DEC = 3'h2,
        CCSER_HEX = 3'h3,
        CCSER_SEP = 3'h4,
        CCSER_DELIM = 3'h5
    } ccser_kind_t;

    typedef enum logic [1:0] {
        CCSER_IDLE = 2'b01,
        CCSER_SHIFT = 2'b10
    } ccser_state_t;

endpackage : ccser_pkg

// ---- core/ccser_if.sv ----
`timescale 1ns/1ps
interface ccser_if #(
    parameter int W = 9
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic [$clog2(W+64):0] level;

    modport buffer (
        input in_valid,
        output in_ready,
        input in_data,
        output out_valid,
        input out_ready,
        output out_data,
        output level
    );

    modport user (
        output in_valid,
        input in_ready,
        output in_data,
        input out_valid,
        output out_ready,
        input out_data,
        input level
    );
endinterface : ccser_if

// ---- core/ccser_fifo.sv ----
`timescale 1ns/1ps
module ccser_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // both sides
    ccser_if.buffer port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [WIDTH-1:0] head_q;
    logic head_v_q;

    wire push = port.in_valid && port.in_ready;
    // head register refills whenever memory holds a word and the head is empty or being drained
    wire load = (cnt_q != '0) && (!head_v_q || port.out_ready);

    assign port.in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign port.out_valid = head_v_q;
    assign port.out_data = head_q;
    assign port.level = ($bits(port.level))'(cnt_q) + ($bits(port.level))'(head_v_q);

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q] <= port.in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            head_q <= '0;
            head_v_q <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (load)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
                head_q <= mem[rd_q];
                head_v_q <= 1'b1;
            end
            else if (port.out_ready)
            begin
                head_v_q <= 1'b0;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
        end
    end
endmodule : ccser_fifo

// ---- core/ccser_top.sv ----
`timescale 1ns/1ps
`include "ccser_cfg.svh"
module ccser_top #(
    parameter int DEPTH = `CCSER_FIFO_DEPTH
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // upstream byte source
    input wire logic S_VALID,
    output logic S_READY,
    input wire logic [7:0] S_DATA,
    input wire logic [7:0] S_RSVD,
    input wire logic [2:0] S_KIND,
    input wire logic S_LAST,
    input wire logic S_TA,
    // serial link towards the remote entity
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic TX_BIT,
    output logic TX_SOF,
    output logic TX_EOF,
    // status
    output logic BUSY,
    output logic REJ_PULSE,
    output logic ERR_TOPBIT,
    output logic ERR_SUBSET,
    input wire logic ERR_CLR
);
    localparam int W = `CCSER_BYTE_W + 1;

    function automatic logic in_rng(input logic [7:0] c, input logic [7:0] lo,
                                    input logic [7:0] hi);
        in_rng = (c >= lo) && (c <= hi);
    endfunction : in_rng

    // a new event in the clearing cycle must not be lost, so the set term wins
    function automatic logic sticky_nx(input logic set, input logic flag, input logic clr);
        sticky_nx = set || (flag && !clr);
    endfunction : sticky_nx

    ccser_if #(.W(W)) q_if ();

    ccser_fifo #(
        .WIDTH(W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RESETN),
        .port(q_if.buffer)
    );

    // input character classification
    ccser_pkg::ccser_kind_t kind;
    wire [7:0] ch = S_DATA;
    wire is_char = (kind != ccser_pkg::CCSER_RAW);
    wire top_clear = !ch[`CCSER_TOP_BIT];
    wire is_dig = in_rng(ch, `CCSER_CH_DIG0, `CCSER_CH_DIG9);
    wire is_hex_letter = in_rng(ch, `CCSER_CH_HEX_A, `CCSER_CH_HEX_F);
    wire is_space = (ch == `CCSER_CH_SPACE);
    wire is_semi = (ch == `CCSER_CH_SEMI);
    wire is_crlf = (ch == `CCSER_CH_CR) || (ch == `CCSER_CH_LF);
    wire g0_ok = in_rng(ch, `CCSER_CH_G0_LO, `CCSER_CH_G0_HI) && !is_semi;
    wire text_ok = g0_ok || (S_TA && is_crlf);
    wire sep_ok = is_space;
    wire delim_ok = is_semi;
    wire hex_ok = is_dig || is_hex_letter;
    logic dec_first_q;
    logic dec_lead0_q;
    // a digit after a lone leading zero would make that zero a leading one
    wire dec_ok = is_dig && !dec_lead0_q;
    wire subset_ok = (kind == ccser_pkg::CCSER_TEXT) ? text_ok :
                     (kind == ccser_pkg::CCSER_DEC) ? dec_ok :
                     (kind == ccser_pkg::CCSER_HEX) ? hex_ok :
                     (kind == ccser_pkg::CCSER_SEP) ? sep_ok :
                     (kind == ccser_pkg::CCSER_DELIM) ? delim_ok : 1'b0;
    wire legal = !is_char || (top_clear && subset_ok);
    wire take = S_VALID && q_if.in_ready;
    wire push = take && legal;
    wire reject = take && !legal;
    // one mask bit per data bit; a reserved bit can never reach the line as a one
    wire [7:0] clean;
    for (genvar b = 0; b < 8; b++)
    begin : g_rsvd
        assign clean[b] = S_DATA[b] && !S_RSVD[b];
    end

    assign kind = ccser_pkg::ccser_kind_t'(S_KIND);
    // rejected characters are consumed too, so a bad byte cannot wedge the source
    assign S_READY = q_if.in_ready;
    assign q_if.in_valid = push;
    assign q_if.in_data = {S_LAST, clean};

    // decimal field tracking, restarted by any accepted non-decimal byte
    wire dec_acc = push && (kind == ccser_pkg::CCSER_DEC);
    wire dec_end = push && (kind != ccser_pkg::CCSER_DEC);
    wire dec_first_d = dec_acc ? 1'b0 : (dec_end ? 1'b1 : dec_first_q);
    wire dec_lead0_d = dec_acc ? (dec_first_q && (ch == `CCSER_CH_DIG0)) :
                       (dec_end ? 1'b0 : dec_lead0_q);

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            dec_first_q <= 1'b1;
        end
        else
        begin
            dec_first_q <= dec_first_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            dec_lead0_q <= 1'b0;
        end
        else
        begin
            dec_lead0_q <= dec_lead0_d;
        end
    end

    // error reporting; a new error in the clearing cycle wins
    logic rej_q;
    logic err_top_q;
    logic err_sub_q;
    wire top_bad = reject && is_char && !top_clear;
    wire sub_bad = reject && top_clear;
    wire err_top_d = sticky_nx(top_bad, err_top_q, ERR_CLR);
    wire err_sub_d = sticky_nx(sub_bad, err_sub_q, ERR_CLR);

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            rej_q <= 1'b0;
        end
        else
        begin
            rej_q <= reject;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            err_top_q <= 1'b0;
        end
        else
        begin
            err_top_q <= err_top_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            err_sub_q <= 1'b0;
        end
        else
        begin
            err_sub_q <= err_sub_d;
        end
    end

    assign REJ_PULSE = rej_q;
    assign ERR_TOPBIT = err_top_q;
    assign ERR_SUBSET = err_sub_q;

    // serializer
    ccser_pkg::ccser_state_t state_q;
    ccser_pkg::ccser_state_t state_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic sof_q;
    logic sof_d;
    logic eof_q;
    logic eof_d;
    logic frame_open_q;
    logic frame_open_d;

    wire idle = (state_q == ccser_pkg::CCSER_IDLE);
    wire shifting = (state_q == ccser_pkg::CCSER_SHIFT);
    // one byte is popped at a time and fully shifted before the next: the
    // fifo order is the byte order, so frames cannot interleave
    wire pop = idle && q_if.out_valid;
    wire bit_taken = shifting && TX_READY;
    wire byte_done = bit_taken && (bit_q == `CCSER_BIT_LAST);
    wire pop_last = q_if.out_data[W-1];

    assign q_if.out_ready = pop;

    always_comb
    begin
        state_d = state_q;
        sh_d = sh_q;
        bit_d = bit_q;
        sof_d = sof_q;
        eof_d = eof_q;
        frame_open_d = frame_open_q;
        unique case (state_q)
            ccser_pkg::CCSER_IDLE:
            begin
                if (pop)
                begin
                    state_d = ccser_pkg::CCSER_SHIFT;
                    sh_d = q_if.out_data[7:0];
                    bit_d = '0;
                    sof_d = !frame_open_q;
                    eof_d = pop_last;
                    frame_open_d = !pop_last;
                end
            end
            ccser_pkg::CCSER_SHIFT:
            begin
                if (byte_done)
                begin
                    state_d = ccser_pkg::CCSER_IDLE;
                    // marks drop with the byte so the frame outputs come straight from flops
                    sof_d = 1'b0;
                    eof_d = 1'b0;
                end
                else if (bit_taken)
                begin
                    // the MSb of the value is bit position zero, so it leaves first
                    sh_d = {sh_q[6:0], 1'b0};
                    bit_d = bit_q + 3'h1;
                end
            end
            default:
            begin
                state_d = ccser_pkg::CCSER_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            state_q <= ccser_pkg::CCSER_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            sh_q <= '0;
        end
        else
        begin
            sh_q <= sh_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            bit_q <= '0;
        end
        else
        begin
            bit_q <= bit_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            sof_q <= 1'b0;
            eof_q <= 1'b0;
        end
        else
        begin
            sof_q <= sof_d;
            eof_q <= eof_d;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            frame_open_q <= 1'b0;
        end
        else
        begin
            frame_open_q <= frame_open_d;
        end
    end

    assign TX_VALID = shifting;
    assign TX_BIT = sh_q[7];
    assign TX_SOF = sof_q;
    assign TX_EOF = eof_q;
    assign BUSY = shifting || q_if.out_valid || (q_if.level != '0);
endmodule : ccser_top

// ---- verif/ccser_top_props.sv ----
`timescale 1ns/1ps
module ccser_top_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // source
    input wire logic S_VALID,
    input wire logic S_READY,
    input wire logic [7:0] S_DATA,
    input wire logic [2:0] S_KIND,
    // link
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_BIT,
    input wire logic TX_SOF,
    input wire logic TX_EOF,
    // status
    input wire logic REJ_PULSE,
    input wire logic ERR_TOPBIT,
    input wire logic ERR_SUBSET,
    input wire logic ERR_CLR
);
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_d;
    wire take = S_VALID && S_READY;
    wire step = TX_VALID && TX_READY;
    assign bit_cnt_d = step ? bit_cnt_q + 3'h1 : bit_cnt_q;
    always_ff @(posedge MCLK)
    begin
        bit_cnt_q <= RESETN ? bit_cnt_d : 3'h0;
    end
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    rst_quiet_a: assert property ($rose(RESETN) |-> !TX_VALID && S_READY && !ERR_TOPBIT)
        else $error("outputs not quiet after reset");
    stall_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BIT))
        else $error("bit moved while stalled");
    byte_gap_a: assert property (step && bit_cnt_q == 3'h7 |=> !TX_VALID)
        else $error("no idle cycle after byte");
    frame_mark_a: assert property (step && bit_cnt_q != 3'h7 |=> $stable(TX_SOF) && $stable(TX_EOF))
        else $error("frame mark moved inside byte");
    topbit_rej_a: assert property (take && S_KIND inside {[1:5]} && S_DATA[7] |=> ERR_TOPBIT)
        else $error("top bit not flagged");
    text_sub_a: assert property (take && S_KIND == 3'h1 && S_DATA inside {8'h20, 8'h3B}
        |=> REJ_PULSE && ERR_SUBSET)
        else $error("space or semicolon passed as text");
    hex_case_a: assert property (take && S_KIND == 3'h3 && S_DATA inside {[8'h61:8'h66]}
        |=> REJ_PULSE && ERR_SUBSET)
        else $error("lower case hex letter passed");
    sticky_err_a: assert property (ERR_SUBSET && !ERR_CLR |=> ERR_SUBSET)
        else $error("sticky flag dropped");
    clear_err_a: assert property (ERR_CLR |=> REJ_PULSE || !(ERR_TOPBIT || ERR_SUBSET))
        else $error("flags not cleared");
endmodule : ccser_top_props
bind ccser_top ccser_top_props u_props (.MCLK(MCLK), .RESETN(RESETN), .S_VALID(S_VALID),
    .S_READY(S_READY), .S_DATA(S_DATA), .S_KIND(S_KIND), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_BIT(TX_BIT), .TX_SOF(TX_SOF), .TX_EOF(TX_EOF),
    .REJ_PULSE(REJ_PULSE), .ERR_TOPBIT(ERR_TOPBIT), .ERR_SUBSET(ERR_SUBSET), .ERR_CLR(ERR_CLR));

// ---- verif/ccser_link_model.sv ----
`timescale 1ns/1ps
module ccser_link_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_bit,
    input wire logic tx_sof,
    input wire logic tx_eof,
    // control and result
    input wire logic hold,
    output logic got_v,
    output logic [9:0] got
);
    logic [2:0] cnt_q;
    logic [6:0] sh_q;
    initial
    begin
        tx_ready = 1'b0;
        got_v = 1'b0;
    end
    always @(posedge clk)
    begin
        got_v <= 1'b0;
        // random stalls make the sender hold its bit
        tx_ready <= !hold && ($urandom % 4 != 0);
        if (!rst_n)
            cnt_q <= 3'h0;
        else if (tx_valid && tx_ready)
        begin
            sh_q <= {sh_q[5:0], tx_bit};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
                got_v <= 1'b1;
                got <= {tx_sof, tx_eof, sh_q, tx_bit};
            end
        end
    end
endmodule : ccser_link_model

// ---- verif/tb_control_char_serializer.sv ----
`timescale 1ns/1ps
module tb_control_char_serializer;
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic S_VALID = 1'b0;
    logic [7:0] S_DATA = 8'h00;
    logic [7:0] S_RSVD = 8'h00;
    logic [2:0] S_KIND = 3'h0;
    logic S_LAST = 1'b0;
    logic S_TA = 1'b0;
    logic ERR_CLR = 1'b0;
    logic hold = 1'b0;
    logic S_READY, TX_VALID, TX_READY, TX_BIT, TX_SOF, TX_EOF, BUSY, REJ_PULSE;
    logic ERR_TOPBIT, ERR_SUBSET, got_v, sof_n, dec_open, dec_zero;
    logic [9:0] got;
    logic [1:0] code;
    logic [9:0] exp_q[$];
    logic [1:0] rej_q[$];
    int failures = 0;
    int n_compared = 0;
    logic [11:0] cases [23] = '{12'h141, 12'h120, 12'h420, 12'h13B, 12'h17E, 12'h17F,
        12'h121, 12'h230, 12'h235, 12'h420, 12'h231, 12'h230, 12'h330, 12'h346, 12'h361,
        12'h347, 12'h10D, 12'h90D, 12'h90A, 12'h1C1, 12'h641, 12'h73B, 12'h53B};
    always #20 MCLK = ~MCLK;
    ccser_top dut (.MCLK(MCLK), .RESETN(RESETN), .S_VALID(S_VALID), .S_READY(S_READY),
        .S_DATA(S_DATA), .S_RSVD(S_RSVD), .S_KIND(S_KIND), .S_LAST(S_LAST), .S_TA(S_TA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_BIT(TX_BIT), .TX_SOF(TX_SOF),
        .TX_EOF(TX_EOF), .BUSY(BUSY), .REJ_PULSE(REJ_PULSE), .ERR_TOPBIT(ERR_TOPBIT),
        .ERR_SUBSET(ERR_SUBSET), .ERR_CLR(ERR_CLR));
    ccser_link_model u_link (.clk(MCLK), .rst_n(RESETN), .tx_valid(TX_VALID),
        .tx_ready(TX_READY), .tx_bit(TX_BIT), .tx_sof(TX_SOF), .tx_eof(TX_EOF),
        .hold(hold), .got_v(got_v), .got(got));
    task automatic cmp_byte(input string what, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input string what, input logic e, input logic g);
        cmp_byte(what, {9'h000, e}, {9'h000, g});
    endtask : cmp_bit
    function automatic logic ok(input logic [2:0] k, input logic [7:0] d, input logic ta);
        logic dig;
        dig = d >= 8'h30 && d <= 8'h39;
        case (k)
            3'h0: ok = 1'b1;
            3'h1: ok = (d >= 8'h21 && d <= 8'h7E && d != 8'h3B) || (ta && d inside {8'h0D, 8'h0A});
            3'h2: ok = dig && !(dec_open && dec_zero);
            3'h3: ok = dig || (d >= 8'h41 && d <= 8'h46);
            3'h4: ok = d == 8'h20;
            3'h5: ok = d == 8'h3B;
            default: ok = 1'b0;
        endcase
    endfunction : ok
    // called just after an edge; the byte is taken at the next edge with room
    task automatic send(input logic [2:0] k, input logic [7:0] d, input logic [7:0] m,
        input logic l, input logic ta);
        int n;
        S_VALID = 1'b1;
        S_KIND = k;
        S_DATA = d;
        S_RSVD = m;
        S_LAST = l;
        S_TA = ta;
        for (n = 0; n < 500 && S_READY !== 1'b1; n++)
            @(posedge MCLK) #1;
        if (ok(k, d, ta))
        begin
            exp_q.push_back({sof_n, l, d & ~m});
            sof_n = l;
            dec_zero = k == 3'h2 ? (dec_open ? dec_zero : d == 8'h30) : 1'b0;
            dec_open = k == 3'h2;
        end
        else
            rej_q.push_back(k > 3'h5 ? 2'h0 : (d[7] ? 2'h2 : 2'h1));
        @(posedge MCLK) #1;
    endtask : send
    task automatic wait_idle;
        int n;
        S_VALID = 1'b0;
        for (n = 0; n < 3000 && (BUSY !== 1'b0 || exp_q.size() != 0); n++)
            @(posedge MCLK) #1;
        repeat (2) @(posedge MCLK) #1;
        cmp_bit("queues drained", 1'b1, exp_q.size() == 0 && rej_q.size() == 0);
        cmp_bit("busy after drain", 1'b0, BUSY);
    endtask : wait_idle
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    always @(negedge MCLK)
    begin
        if (got_v === 1'b1)
            cmp_byte("line byte", exp_q.size() ? exp_q.pop_front() : 10'h3FF, got);
        if (REJ_PULSE === 1'b1 && rej_q.size() == 0)
            cmp_bit("unexpected reject", 1'b0, 1'b1);
        else if (REJ_PULSE === 1'b1)
        begin
            code = rej_q.pop_front();
            if (code == 2'h2)
                cmp_bit("top bit flag", 1'b1, ERR_TOPBIT);
            if (code == 2'h1)
                cmp_bit("subset flag", 1'b1, ERR_SUBSET);
        end
    end
    initial
    begin
        #2000000;
        failures++;
        wrap_up;
    end
    initial
    begin
        int i;
        int sel;
        sof_n = 1'b1;
        dec_open = 1'b0;
        dec_zero = 1'b0;
        void'($urandom(60947));
        repeat (5) @(posedge MCLK);
        #1;
        RESETN = 1'b1;
        @(posedge MCLK) #1;
        cmp_bit("ready after reset", 1'b1, S_READY);
        cmp_bit("flag after reset", 1'b0, ERR_SUBSET);
        foreach (cases[j])
            send(cases[j][10:8], cases[j][7:0], 8'h00, j == 22, cases[j][11]);
        wait_idle;
        ERR_CLR = 1'b1;
        @(posedge MCLK) #1;
        ERR_CLR = 1'b0;
        cmp_bit("flag cleared", 1'b0, ERR_TOPBIT);
        cmp_bit("subset flag cleared", 1'b0, ERR_SUBSET);
        for (i = 0; i < 300; i++)
        begin
            ERR_CLR = $urandom % 16 == 0;
            sel = $urandom % 3;
            send(sel == 0 ? 3'($urandom) : 3'h0, 8'($urandom), sel == 0 ? 8'h00 : 8'($urandom),
                $urandom % 5 == 0, 1'($urandom));
        end
        ERR_CLR = 1'b0;
        wait_idle;
        hold = 1'b1;
        for (i = 0; i < 30 && S_READY === 1'b1; i++)
            send(3'h0, 8'($urandom), 8'h00, 1'b0, 1'b0);
        cmp_bit("buffer full", 1'b0, S_READY);
        // eight memory words, the head register and the byte stalled in the shifter
        cmp_byte("buffer depth", 10'h00A, 10'(i));
        hold = 1'b0;
        wait_idle;
        wrap_up;
    end
endmodule : tb_control_char_serializer
